// ===== rtl/nested_irq_ctrl.sv
// two-level nested interrupt controller of an 8-bit microcontroller
// assumes core timing strobes on mclk, peripheral set pulses on mclk,
// external and capture pins asynchronous
// Operation
// R01: fifteen sources, each with request flag, enable and priority bit.
// R02: two external inputs, each level or edge by own select bit.
// R03: edge external flag cleared at vectoring; level flag left alone.
// R04: level flag follows the pin; source holds request until served.
// R05: external inputs are active low, allowing wired-or sources.
// R06: timer a/b overflow flags set on rollover, cleared at vectoring.
// R07: third timer gives four capture, three compare, one overflow source.
// R08: uart request is rx-done or tx-done; neither cleared at vectoring.
// R09: two-wire request from its event flag, cleared only by software.
// R10: adc flag set at scan end; software clears only, cannot set.
// R11: one-hz tick flag ored into source b; cleared only by software.
// R12: software set or clear acts as hardware would, except adc set.
// R13: only ext a/b, timers a/b, tick, uart, two-wire end idle.
// R14: per-source enable plus global gate blocking everything.
// R15: per-source priority bit, 0 low, 1 high.
// R16: high preempts low handler; nothing preempts high handler.
// R17: high before low; equal levels resolved by fixed polling order.
// R18: sample at s5p2 each machine cycle, poll in the next.
// R19: withhold call during equal/higher handler or before final cycle.
// R20: after return or enable/level access, wait one more instruction.
// R21: capture pins may act as extra requests on rise, fall or both.
// R22: no memory of blocked requests; each poll uses fresh samples.
// R23: call pushes pc without status word, loads source vector.
// R24: return clears active-level flag set at acknowledge.
// R25: polling order ext a, tw, adc, tmr a, cap0 ... t3 overflow.
// R26: source polled only when flag, own enable and gate all set.
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module nested_irq_ctrl (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              ext_request_pin_a,
  input  wire logic              ext_request_pin_b,
  input  wire logic [3:0]        capture_input_pin,
  input  wire logic              ext_a_edge_select,
  input  wire logic              ext_b_edge_select,
  input  wire logic [3:0]        cap_pin_mode,
  input  wire logic [3:0]        cap_rise_en,
  input  wire logic [3:0]        cap_fall_en,
  input  wire logic              timer_a_overflow_set,
  input  wire logic              timer_b_overflow_set,
  input  wire logic [3:0]        t3_capture_set,
  input  wire logic [2:0]        t3_compare_set,
  input  wire logic              t3_overflow_set,
  input  wire logic              uart_rx_done_set,
  input  wire logic              uart_tx_done_set,
  input  wire logic              twowire_event_set,
  input  wire logic              adc_scan_done_set,
  input  wire logic              one_hz_tick_set,
  input  wire logic [`NFLAG-1:0] sw_flag_wr,
  input  wire logic [`NFLAG-1:0] sw_flag_wdata,
  input  wire logic [7:0]        irq_enable_reg_a,
  input  wire logic [7:0]        irq_enable_reg_b,
  input  wire logic [7:0]        irq_level_reg_a,
  input  wire logic [7:0]        irq_level_reg_b,
  input  wire logic              machine_s5p2,
  input  wire logic              cpu_final_cycle,
  input  wire logic              cpu_instr_retire,
  input  wire logic              irq_return_op,
  input  wire logic              irq_reg_access,
  output logic                   hw_vector_call,
  output logic [`VEC_W-1:0]      vector_addr,
  output logic [3:0]             vector_source,
  output logic                   vector_level_high,
  output logic                   high_level_active,
  output logic                   low_level_active,
  output logic [`NFLAG-1:0]      request_flags,
  output logic                   idle_wake
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  pin_sync_if ps ();

  pin_sync u_sync (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pin_raw ({capture_input_pin, ext_request_pin_b, ext_request_pin_a}),
    .sync    (ps.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // state and helpers

  irq_pkg::ctrl_state_t st_q;
  irq_pkg::ctrl_state_t st_d;

  localparam irq_pkg::ctrl_state_t CTRL_RST = '{
    flags:    '0,
    pin_prev: `PIN_IDLE,
    sample:   '0,
    poll:     irq_pkg::POLL_IDLE,
    hi_act:   1'b0,
    lo_act:   1'b0,
    hold:     1'b0,
    call:     1'b0,
    call_hi:  1'b0,
    vec_addr: '0,
    vec_src:  '0,
    wake:     1'b0
  };

  // reorder register bits into polling order
  function automatic logic [`NSRC-1:0] to_src(input logic [7:0] ra,
                                              input logic [7:0] rb);
    logic [`NSRC-1:0] s;
    s                = '0;
    s[`SRC_EXT_A]    = ra[`RA_EXT_A];
    s[`SRC_TW]       = ra[`RA_TW];
    s[`SRC_ADC]      = ra[`RA_ADC];
    s[`SRC_TMR_A]    = ra[`RA_TMR_A];
    s[`SRC_CAP0]     = rb[`RB_CAP0];
    s[`SRC_CMP0]     = rb[`RB_CMP0];
    s[`SRC_EXT_B]    = ra[`RA_EXT_B];
    s[`SRC_CAP1]     = rb[`RB_CAP0+1];
    s[`SRC_CMP1]     = rb[`RB_CMP0+1];
    s[`SRC_TMR_B]    = ra[`RA_TMR_B];
    s[`SRC_CAP2]     = rb[`RB_CAP0+2];
    s[`SRC_CMP2]     = rb[`RB_CMP0+2];
    s[`SRC_UART]     = ra[`RA_UART];
    s[`SRC_CAP3]     = rb[`RB_CAP0+3];
    s[`SRC_T3OVF]    = rb[`RB_T3OVF];
    return s;
  endfunction

  // lowest set position wins; bit 4 marks a hit
  function automatic logic [4:0] pick(input logic [`NSRC-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = `NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // capture pins as extra external requests

  logic [`NPIN-1:0] pin_lvl;
  logic [`NPIN-1:0] pin_rise;
  logic [`NPIN-1:0] pin_fall;
  logic [3:0]       cap_set;

  assign pin_lvl  = ps.level;
  // edges of filtered levels; prev resets idle high, no false edge
  assign pin_rise = pin_lvl & ~st_q.pin_prev;
  assign pin_fall = st_q.pin_prev & ~pin_lvl;

  for (genvar i = 0; i < 4; i++) begin : g_cap
    assign cap_set[i] = cap_pin_mode[i] ?
      ((pin_rise[i+2] & cap_rise_en[i]) |
       (pin_fall[i+2] & cap_fall_en[i])) :                        // R21
      t3_capture_set[i];                                          // R07
  end

  ////////////////////////////////////////////////////////////////////////
  // request, enable and priority vectors

  logic [`NSRC-1:0]  req;
  logic [`NSRC-1:0]  en;
  logic [`NSRC-1:0]  pri;
  logic              gate;
  logic [`NSRC-1:0]  hi_req;
  logic [`NSRC-1:0]  lo_req;
  logic [4:0]        hi_pick;
  logic [4:0]        lo_pick;
  logic [`NFLAG-1:0] hw_set;
  logic [`NFLAG-1:0] sw_set;
  logic [`NFLAG-1:0] sw_clr;

  // flags folded into polling positions
  always_comb begin
    req              = '0;
    req[`SRC_EXT_A]  = st_q.flags[`FLG_EXT_A];
    req[`SRC_TW]     = st_q.flags[`FLG_TW];                       // R09
    req[`SRC_ADC]    = st_q.flags[`FLG_ADC];
    req[`SRC_TMR_A]  = st_q.flags[`FLG_TMR_A];
    req[`SRC_CAP0]   = st_q.flags[`FLG_CAP0];
    req[`SRC_CMP0]   = st_q.flags[`FLG_CMP0];
    req[`SRC_EXT_B]  = st_q.flags[`FLG_EXT_B] |
                       st_q.flags[`FLG_SEC];                      // R11
    req[`SRC_CAP1]   = st_q.flags[`FLG_CAP0+1];
    req[`SRC_CMP1]   = st_q.flags[`FLG_CMP0+1];
    req[`SRC_TMR_B]  = st_q.flags[`FLG_TMR_B];
    req[`SRC_CAP2]   = st_q.flags[`FLG_CAP0+2];
    req[`SRC_CMP2]   = st_q.flags[`FLG_CMP0+2];
    req[`SRC_UART]   = st_q.flags[`FLG_RX] | st_q.flags[`FLG_TX]; // R08
    req[`SRC_CAP3]   = st_q.flags[`FLG_CAP0+3];
    req[`SRC_T3OVF]  = st_q.flags[`FLG_T3OVF];
  end

  assign en      = to_src(irq_enable_reg_a, irq_enable_reg_b);     // R14
  assign pri     = to_src(irq_level_reg_a, irq_level_reg_b);       // R15
  assign gate    = irq_enable_reg_a[`RA_GLOBAL];
  assign hi_req  = st_q.sample & pri;                              // R17
  assign lo_req  = st_q.sample & ~pri;
  assign hi_pick = pick(hi_req);                                   // R25
  assign lo_pick = pick(lo_req);

  // hardware set pulses placed at flag positions
  always_comb begin
    hw_set                  = '0;
    hw_set[`FLG_EXT_A]      = pin_fall[0];                         // R05
    hw_set[`FLG_EXT_B]      = pin_fall[1];
    hw_set[`FLG_TMR_A]      = timer_a_overflow_set;                // R06
    hw_set[`FLG_TMR_B]      = timer_b_overflow_set;
    hw_set[`FLG_CAP0+3:`FLG_CAP0] = cap_set;
    hw_set[`FLG_CMP0+2:`FLG_CMP0] = t3_compare_set;
    hw_set[`FLG_T3OVF]      = t3_overflow_set;
    hw_set[`FLG_RX]         = uart_rx_done_set;
    hw_set[`FLG_TX]         = uart_tx_done_set;
    hw_set[`FLG_TW]         = twowire_event_set;
    hw_set[`FLG_ADC]        = adc_scan_done_set;                   // R10
    hw_set[`FLG_SEC]        = one_hz_tick_set;
  end

  // software cannot raise the adc flag
  assign sw_set = sw_flag_wr & sw_flag_wdata &
                  ~(`NFLAG'(1) << `FLG_ADC);                       // R12
  assign sw_clr = sw_flag_wr & ~sw_flag_wdata;

  ////////////////////////////////////////////////////////////////////////
  // sampling, polling, vectoring and flag update

  always_comb begin
    logic              can_call;
    logic              call;
    logic              call_hi;
    logic [3:0]        src;
    logic [`NFLAG-1:0] vec_clr;
    st_d     = st_q;
    call     = 1'b0;
    call_hi  = 1'b0;
    src      = '0;
    vec_clr  = '0;
    can_call = (st_q.poll == irq_pkg::POLL_ARMED) && cpu_final_cycle &&
               !st_q.hold && !irq_return_op && !irq_reg_access;  // R19 R20
    st_d.pin_prev = pin_lvl;

    // fresh sample each machine cycle, gated by enables
    if (machine_s5p2) begin
      st_d.sample = req & en & {`NSRC{gate}};                     // R18 R26
      st_d.poll   = irq_pkg::POLL_ARMED;
    end else if (st_q.poll == irq_pkg::POLL_ARMED) begin
      st_d.poll   = irq_pkg::POLL_IDLE;                           // R22
    end

    // high pick may preempt a low handler
    if (can_call && hi_pick[4] && !st_q.hi_act) begin             // R16
      call    = 1'b1;
      call_hi = 1'b1;
      src     = hi_pick[3:0];
    end else if (can_call && lo_pick[4] && !st_q.hi_act &&
                 !st_q.lo_act) begin                              // R16
      call    = 1'b1;
      src     = lo_pick[3:0];
    end

    // edge ext and timer a/b flags drop at the call
    if (call) begin
      if (src == 4'(`SRC_EXT_A) && ext_a_edge_select) begin
        vec_clr[`FLG_EXT_A] = 1'b1;                               // R03
      end
      if (src == 4'(`SRC_EXT_B) && ext_b_edge_select) begin
        vec_clr[`FLG_EXT_B] = 1'b1;                               // R03
      end
      if (src == 4'(`SRC_TMR_A)) begin
        vec_clr[`FLG_TMR_A] = 1'b1;                               // R06
      end
      if (src == 4'(`SRC_TMR_B)) begin
        vec_clr[`FLG_TMR_B] = 1'b1;                               // R06
      end
      st_d.vec_src  = src;
      st_d.vec_addr = `VEC_BASE + `VEC_STEP * `VEC_W'(src);       // R23
      st_d.call_hi  = call_hi;
      st_d.poll     = irq_pkg::POLL_IDLE;
    end
    st_d.call = call;

    // active levels: set on acknowledge, innermost cleared on return
    if (call && call_hi) begin
      st_d.hi_act = 1'b1;
    end else if (call) begin
      st_d.lo_act = 1'b1;
    end else if (irq_return_op && st_q.hi_act) begin
      st_d.hi_act = 1'b0;                                         // R24
    end else if (irq_return_op) begin
      st_d.lo_act = 1'b0;                                         // R24
    end

    // hold until one further instruction retires
    if (irq_return_op || irq_reg_access) begin
      st_d.hold = 1'b1;                                           // R20
    end else if (cpu_instr_retire) begin
      st_d.hold = 1'b0;
    end

    // set wins over any clear
    st_d.flags = (st_q.flags & ~(vec_clr | sw_clr)) | hw_set | sw_set;
    if (!ext_a_edge_select) begin
      st_d.flags[`FLG_EXT_A] = ~pin_lvl[0];                       // R02 R04
    end
    if (!ext_b_edge_select) begin
      st_d.flags[`FLG_EXT_B] = ~pin_lvl[1];                       // R02 R04
    end

    // wake ignores priority and handler state
    st_d.wake = |(req & en & `WAKE_MASK) & gate;                  // R13
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= CTRL_RST;
    end else begin
      st_q <= st_d;                                               // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // every output is a register field
  assign hw_vector_call    = st_q.call;
  assign vector_addr       = st_q.vec_addr;
  assign vector_source     = st_q.vec_src;
  assign vector_level_high = st_q.call_hi;
  assign high_level_active = st_q.hi_act;
  assign low_level_active  = st_q.lo_act;
  assign request_flags     = st_q.flags;
  assign idle_wake         = st_q.wake;

endmodule

`default_nettype wire

// ===== rtl/irq_params.svh
// constants of the two-level nested interrupt controller
// assumes inclusion by bare name from every file that needs them
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// widths
`define NSRC        15
`define NFLAG       17
`define NPIN        6
`define VEC_W       16

// request flag positions
`define FLG_EXT_A   0
`define FLG_EXT_B   1
`define FLG_TMR_A   2
`define FLG_TMR_B   3
`define FLG_CAP0    4
`define FLG_CMP0    8
`define FLG_T3OVF   11
`define FLG_RX      12
`define FLG_TX      13
`define FLG_TW      14
`define FLG_ADC     15
`define FLG_SEC     16

// source positions in polling order, highest first
`define SRC_EXT_A   0
`define SRC_TW      1
`define SRC_ADC     2
`define SRC_TMR_A   3
`define SRC_CAP0    4
`define SRC_CMP0    5
`define SRC_EXT_B   6
`define SRC_CAP1    7
`define SRC_CMP1    8
`define SRC_TMR_B   9
`define SRC_CAP2    10
`define SRC_CMP2    11
`define SRC_UART    12
`define SRC_CAP3    13
`define SRC_T3OVF   14

// enable / level register a bit positions
`define RA_EXT_A    0
`define RA_TMR_A    1
`define RA_EXT_B    2
`define RA_TMR_B    3
`define RA_UART     4
`define RA_TW       5
`define RA_ADC      6
`define RA_GLOBAL   7
// enable / level register b bit positions
`define RB_CAP0     0
`define RB_CMP0     4
`define RB_T3OVF    7

// sources able to end idle mode
`define WAKE_MASK   15'h124b
// pin sample reset value, pins idle high
`define PIN_IDLE    6'h3f
// vector addresses: base plus step times polling position
`define VEC_BASE    16'h0003
`define VEC_STEP    16'h0008

`endif

// ===== rtl/irq_pkg.sv
// types of the two-level nested interrupt controller
// assumes irq_params.svh on the include path
`include "irq_params.svh"

package irq_pkg;

  typedef enum logic {
    POLL_IDLE,
    POLL_ARMED
  } poll_phase_t;

  typedef struct packed {
    logic [`NPIN-1:0] s1;
    logic [`NPIN-1:0] s2;
    logic [`NPIN-1:0] s3;
    logic [`NPIN-1:0] level;
  } sync_state_t;

  typedef struct packed {
    logic [`NFLAG-1:0] flags;
    logic [`NPIN-1:0]  pin_prev;
    logic [`NSRC-1:0]  sample;
    poll_phase_t       poll;
    logic              hi_act;
    logic              lo_act;
    logic              hold;
    logic              call;
    logic              call_hi;
    logic [`VEC_W-1:0] vec_addr;
    logic [3:0]        vec_src;
    logic              wake;
  } ctrl_state_t;

endpackage

// ===== rtl/pin_sync_if.sv
// carries filtered pin levels from the synchroniser to the controller
// assumes one clock domain on both ends
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

interface pin_sync_if;
  logic [`NPIN-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

`default_nettype wire

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes pins asynchronous to mclk, idle high
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module pin_sync (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [`NPIN-1:0] pin_raw,
  pin_sync_if.src               sync
);

  irq_pkg::sync_state_t st_q;
  irq_pkg::sync_state_t st_d;

  always_comb begin
    st_d       = st_q;
    st_d.s1    = pin_raw;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    // level moves only where stages two and three agree
    st_d.level = (st_q.s2 & st_q.s3) | (st_q.level & (st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= {`PIN_IDLE, `PIN_IDLE, `PIN_IDLE, `PIN_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync.level = st_q.level;

endmodule

`default_nettype wire

// ===== test/core_seq_model.sv
// core sequencer model: machine-cycle strobes for the interrupt block
// assumes one mclk domain, reset active low
`timescale 1ns/1ps
`default_nettype none

module core_seq_model #(
  parameter int MC_LEN = 6
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic two_cycle,
  output logic      machine_s5p2,
  output logic      cpu_final_cycle,
  output logic      cpu_instr_retire
);
  int   ph_q;
  logic second_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q     <= 0;
      second_q <= 1'b0;
    end else if (ph_q == MC_LEN - 1) begin
      ph_q     <= 0;
      second_q <= two_cycle & ~second_q;
    end else begin
      ph_q <= ph_q + 1;
    end
  end

  // one sampling strobe per machine cycle
  assign machine_s5p2     = (ph_q == MC_LEN - 2);
  // two-cycle instructions end on their second machine cycle
  assign cpu_final_cycle  = ~two_cycle | second_q;
  assign cpu_instr_retire = cpu_final_cycle & (ph_q == MC_LEN - 1);
endmodule

`default_nettype wire

// ===== test/nested_irq_ctrl_chk.sv
// concurrent checks on the ports of the interrupt controller
// assumes bind to nested_irq_ctrl, one clock mclk, reset rst_b
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

module nested_irq_ctrl_chk (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              machine_s5p2,
  input wire logic              cpu_final_cycle,
  input wire logic              cpu_instr_retire,
  input wire logic              irq_return_op,
  input wire logic              irq_reg_access,
  input wire logic [7:0]        irq_enable_reg_a,
  input wire logic              timer_a_overflow_set,
  input wire logic              adc_scan_done_set,
  input wire logic [`NFLAG-1:0] sw_flag_wr,
  input wire logic              hw_vector_call,
  input wire logic [`VEC_W-1:0] vector_addr,
  input wire logic [3:0]        vector_source,
  input wire logic              vector_level_high,
  input wire logic              high_level_active,
  input wire logic              low_level_active,
  input wire logic [`NFLAG-1:0] request_flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_poll_not_final;
    machine_s5p2 ##1 !cpu_final_cycle;
  endsequence
  sequence s_blocked_op;
    (irq_return_op || irq_reg_access) ##1 !cpu_instr_retire;
  endsequence

  property p_call_pulse;
    hw_vector_call |=> !hw_vector_call;
  endproperty
  a_call_pulse: assert property (p_call_pulse)
    else $error("call longer than one cycle");
  property p_call_sampled;
    hw_vector_call |-> $past(machine_s5p2, 2);
  endproperty
  a_call_sampled: assert property (p_call_sampled)
    else $error("call without sample two cycles before");
  property p_not_final;
    s_poll_not_final |=> !hw_vector_call;
  endproperty
  a_not_final: assert property (p_not_final)
    else $error("call outside final cycle");
  property p_high_block;
    high_level_active |=> !hw_vector_call;
  endproperty
  a_high_block: assert property (p_high_block)
    else $error("call during high handler");
  property p_low_block;
    low_level_active |=> !hw_vector_call || vector_level_high;
  endproperty
  a_low_block: assert property (p_low_block)
    else $error("low call during low handler");
  property p_active_set;
    hw_vector_call |->
      (vector_level_high ? high_level_active : low_level_active);
  endproperty
  a_active_set: assert property (p_active_set)
    else $error("active level not set at call");
  property p_ret_high;
    irq_return_op && high_level_active |=> !high_level_active;
  endproperty
  a_ret_high: assert property (p_ret_high)
    else $error("return left high level active");
  property p_vec;
    hw_vector_call |->
      vector_addr == `VEC_BASE + `VEC_STEP * {12'h000, vector_source};
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector address wrong");
  property p_gate;
    hw_vector_call |-> $past(irq_enable_reg_a[`RA_GLOBAL], 2);
  endproperty
  a_gate: assert property (p_gate)
    else $error("call with global gate off");
  property p_after_op;
    s_blocked_op |=> !hw_vector_call;
  endproperty
  a_after_op: assert property (p_after_op)
    else $error("call before next instruction");
  property p_tmr_set;
    timer_a_overflow_set |=> request_flags[`FLG_TMR_A];
  endproperty
  a_tmr_set: assert property (p_tmr_set)
    else $error("timer flag not set");
  property p_adc_sw;
    sw_flag_wr[`FLG_ADC] && !adc_scan_done_set && !request_flags[`FLG_ADC]
      |=> !request_flags[`FLG_ADC];
  endproperty
  a_adc_sw: assert property (p_adc_sw)
    else $error("adc flag set by write");
endmodule

bind nested_irq_ctrl nested_irq_ctrl_chk chk (
  .mclk, .rst_b, .machine_s5p2, .cpu_final_cycle, .cpu_instr_retire,
  .irq_return_op, .irq_reg_access, .irq_enable_reg_a,
  .timer_a_overflow_set, .adc_scan_done_set, .sw_flag_wr,
  .hw_vector_call, .vector_addr, .vector_source, .vector_level_high,
  .high_level_active, .low_level_active, .request_flags
);

`default_nettype wire

// ===== test/nested_two_level_interrupt_system_test.sv
// self-checking bench of the two-level interrupt controller
// assumes core_seq_model and the checker bind compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "irq_params.svh"

`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
  end \
end

module nested_two_level_interrupt_system_test;
  logic        mclk = 0, rst_b = 0, pin_a = 1, pin_b = 1;
  logic        edge_a = 0, edge_b = 0, ret_op = 0, reg_acc = 0;
  logic        two_cyc = 0;
  logic [3:0]  cap_pin = '1, cap_mode = '0, cap_rise = '0, cap_fall = '0;
  logic [16:0] hw_set = '0, sw_wr = '0, sw_data = '0, flags;
  logic [7:0]  en_a = '0, en_b = '0, lv_a = '0, lv_b = '0;
  logic        s5p2, final_c, retire, call, lv_hi, hi_act, lo_act, wake;
  logic [15:0] vaddr;
  logic [3:0]  vsrc;
  int          n_mismatch = 0, n_compared = 0;
  int          ord_flag[14] = '{14, 15, 2, 4, 8, 16, 5, 9, 3, 6, 10, 12, 7, 11};

  always #5 mclk = ~mclk;

  core_seq_model core (.mclk(mclk), .rst_b(rst_b), .two_cycle(two_cyc),
    .machine_s5p2(s5p2), .cpu_final_cycle(final_c),
    .cpu_instr_retire(retire));

  nested_irq_ctrl dut (.mclk(mclk), .rst_b(rst_b),
    .ext_request_pin_a(pin_a), .ext_request_pin_b(pin_b),
    .capture_input_pin(cap_pin), .ext_a_edge_select(edge_a),
    .ext_b_edge_select(edge_b), .cap_pin_mode(cap_mode),
    .cap_rise_en(cap_rise), .cap_fall_en(cap_fall),
    .timer_a_overflow_set(hw_set[2]), .timer_b_overflow_set(hw_set[3]),
    .t3_capture_set(hw_set[7:4]), .t3_compare_set(hw_set[10:8]),
    .t3_overflow_set(hw_set[11]), .uart_rx_done_set(hw_set[12]),
    .uart_tx_done_set(hw_set[13]), .twowire_event_set(hw_set[14]),
    .adc_scan_done_set(hw_set[15]), .one_hz_tick_set(hw_set[16]),
    .sw_flag_wr(sw_wr), .sw_flag_wdata(sw_data),
    .irq_enable_reg_a(en_a), .irq_enable_reg_b(en_b),
    .irq_level_reg_a(lv_a), .irq_level_reg_b(lv_b),
    .machine_s5p2(s5p2), .cpu_final_cycle(final_c),
    .cpu_instr_retire(retire), .irq_return_op(ret_op),
    .irq_reg_access(reg_acc), .hw_vector_call(call), .vector_addr(vaddr),
    .vector_source(vsrc), .vector_level_high(lv_hi),
    .high_level_active(hi_act), .low_level_active(lo_act),
    .request_flags(flags), .idle_wake(wake));

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic drive(input logic [16:0] hs, wm, wd);
    @(posedge mclk);
    hw_set  <= hs;
    sw_wr   <= wm;
    sw_data <= wd;
    @(posedge mclk);
    hw_set <= '0;
    sw_wr  <= '0;
  endtask

  task automatic cpu(input logic r, a);
    @(posedge mclk);
    ret_op  <= r;
    reg_acc <= a;
    @(posedge mclk);
    ret_op  <= 1'b0;
    reg_acc <= 1'b0;
  endtask

  task automatic expect_call(input logic [3:0] s, input logic h);
    int i;
    for (i = 0; i < 60 && call !== 1'b1; i++) @(negedge mclk);
    if (i == 60) begin
      n_mismatch++;
      summarize();
    end
    `CHK(vsrc, s)
    `CHK(vaddr, `VEC_BASE + `VEC_STEP * {12'h000, s})
    `CHK(lv_hi, h)
    `CHK(h ? hi_act : lo_act, 1'b1)
  endtask

  task automatic expect_none(input int n);
    repeat (n) begin
      @(negedge mclk);
      `CHK(call, 1'b0)
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(negedge mclk);
    `CHK(flags, 17'h0_0000)
    `CHK({call, hi_act, lo_act}, 3'b000)
    @(posedge mclk);
    en_a <= 8'hff;
    en_b <= 8'hff;
    drive(17'h1_dffc, '0, '0);
    for (int k = 0; k < 14; k++) begin
      expect_call(4'(k + 1), 1'b0);
      `CHK(flags[ord_flag[k]], !(ord_flag[k] inside {2, 3}))
      drive('0, 17'h1 << ord_flag[k], '0);
      cpu(1'b1, 1'b0);
    end
    drive('0, 17'h0_a000, 17'h0_a000);
    @(negedge mclk);
    `CHK(flags[15], 1'b0)
    `CHK(flags[13], 1'b1)
    expect_call(4'd12, 1'b0);
    drive('0, 17'h0_2000, '0);
    cpu(1'b1, 1'b0);
    @(posedge mclk);
    en_a <= 8'h7f;
    en_b <= 8'hfe;
    drive(17'h0_0014, '0, '0);
    expect_none(20);
    `CHK(wake, 1'b0)
    drive('0, 17'h0_0004, '0);
    @(posedge mclk);
    en_a <= 8'hff;
    cpu(1'b0, 1'b1);
    expect_none(20);
    `CHK(wake, 1'b0)
    @(posedge mclk);
    en_b <= 8'hff;
    expect_call(4'd4, 1'b0);
    `CHK(wake, 1'b0)
    drive('0, 17'h0_0010, '0);
    cpu(1'b1, 1'b0);
    drive(17'h0_0004, '0, '0);
    repeat (2) @(negedge mclk);
    `CHK(wake, 1'b1)
    expect_call(4'd3, 1'b0);
    cpu(1'b1, 1'b0);
    @(posedge mclk);
    two_cyc <= 1'b1;
    lv_b    <= 8'h41;
    drive(17'h0_0008, '0, '0);
    expect_call(4'd9, 1'b0);
    drive(17'h0_0010, '0, '0);
    expect_call(4'd4, 1'b1);
    drive(17'h0_0004, '0, '0);
    expect_none(30);
    drive('0, 17'h0_0010, '0);
    cpu(1'b1, 1'b0);
    expect_none(30);
    cpu(1'b1, 1'b0);
    expect_call(4'd3, 1'b0);
    cpu(1'b1, 1'b0);
    drive(17'h0_4400, '0, '0);
    expect_call(4'd11, 1'b1);
    drive('0, 17'h0_0400, '0);
    cpu(1'b1, 1'b0);
    expect_call(4'd1, 1'b0);
    drive('0, 17'h0_4000, '0);
    cpu(1'b1, 1'b0);
    @(posedge mclk);
    two_cyc <= 1'b0;
    edge_a  <= 1'b1;
    pin_a   <= 1'b0;
    expect_call(4'd0, 1'b0);
    `CHK(flags[0], 1'b0)
    @(posedge mclk);
    pin_a  <= 1'b1;
    cpu(1'b1, 1'b0);
    @(posedge mclk);
    pin_b <= 1'b0;
    expect_call(4'd6, 1'b0);
    `CHK(flags[1], 1'b1)
    @(posedge mclk);
    pin_b <= 1'b1;
    repeat (10) @(negedge mclk);
    `CHK(flags[1], 1'b0)
    cpu(1'b1, 1'b0);
    expect_none(20);
    @(posedge mclk);
    en_a     <= 8'h7f;
    cap_mode <= 4'h2;
    cap_rise <= 4'h2;
    cap_pin  <= 4'hd;
    repeat (10) @(negedge mclk);
    `CHK(flags[5], 1'b0)
    @(posedge mclk);
    cap_pin <= 4'hf;
    repeat (10) @(negedge mclk);
    `CHK(flags[5], 1'b1)
    @(posedge mclk);
    sw_wr    <= 17'h0_0020;
    cap_rise <= 4'h0;
    cap_fall <= 4'h2;
    cap_pin  <= 4'hd;
    @(posedge mclk);
    sw_wr <= '0;
    @(negedge mclk);
    `CHK(flags[5], 1'b0)
    repeat (10) @(negedge mclk);
    `CHK(flags[5], 1'b1)
    summarize();
  end
endmodule

`default_nettype wire
